/* shared/isp_pkg.sv */
// Constants for the interval serial port: register map, field layout and timing.
// Assumes a 32-bit APB with each 16-bit register in the low half of an aligned word.
package isp_pkg;

    // ****************************************************************
    // Register indices and byte addresses
    // ****************************************************************
    localparam logic [31:0] ISP_SERIAL_DATA_IDX = 32'h10008000;
    localparam logic [31:0] ISP_SERIAL_CONTROL_IDX = 32'h10008002;
    localparam logic [31:0] ISP_INTERVAL_CONTROL_IDX = 32'h10008004;
    localparam logic [31:0] ISP_SERIAL_STATUS_IDX = 32'h10008006;
    localparam logic [31:0] ISP_SERIAL_DATA_ADDR = ISP_SERIAL_DATA_IDX << 2;
    localparam logic [31:0] ISP_SERIAL_CONTROL_ADDR = ISP_SERIAL_CONTROL_IDX << 2;
    localparam logic [31:0] ISP_INTERVAL_CONTROL_ADDR = ISP_INTERVAL_CONTROL_IDX << 2;
    localparam logic [31:0] ISP_SERIAL_STATUS_ADDR = ISP_SERIAL_STATUS_IDX << 2;

    // ****************************************************************
    // Register width and reset values
    // ****************************************************************
    localparam int ISP_REG_W = 16;
    localparam logic [15:0] ISP_SERIAL_DATA_RST = 16'h0000;
    localparam logic [15:0] ISP_SERIAL_CONTROL_RST = 16'h0000;
    localparam logic [15:0] ISP_INTERVAL_CONTROL_RST = 16'h0000;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int ISP_CTL_DOZE_DISABLE = 15;
    localparam int ISP_CTL_ENABLE = 14;
    localparam int ISP_CTL_SELECT_SENSE = 13;
    localparam int ISP_CTL_DRIVE_TYPE = 12;
    localparam int ISP_CTL_MASTER_SELECT = 11;
    localparam int ISP_CTL_IRQ_ENABLE = 10;
    localparam int ISP_CTL_CLOCK_PHASE = 9;
    localparam int ISP_CTL_CLOCK_POLARITY = 8;
    localparam int ISP_CTL_GP_PIN_LEVEL = 7;
    localparam int ISP_CTL_RATE_LSB = 4;
    localparam int ISP_CTL_RATE_W = 3;
    localparam int ISP_CTL_COUNT_LSB = 0;
    localparam int ISP_CTL_COUNT_W = 4;
    localparam int ISP_IVL_LOOPBACK_ENABLE = 15;
    localparam int ISP_IVL_INTERVAL_ENABLE = 14;
    localparam int ISP_IVL_COUNT_LSB = 0;
    localparam int ISP_IVL_COUNT_W = 14;
    localparam int ISP_STS_OVERRUN_FLAG = 15;
    localparam int ISP_STS_IRQ_PENDING = 14;
    localparam int ISP_STS_EXCHANGE_IN_PROGRESS = 13;

    // ****************************************************************
    // Timing: half a bit period at rate code 000 (divide by 8)
    // ****************************************************************
    localparam int ISP_DIV_W = 10;
    localparam logic [ISP_DIV_W:0] ISP_HALF_DIV_BASE = 11'h004;

endpackage

/* rtl/isp_interval_serial_port.sv */
// Interval serial port: APB register file, bit clock divider, shift engine for master
// (manual and interval) and slave operation, and the pin drivers.
// Assumes pclk is the reference clock and that the testbench resolves the pin wires.
`timescale 1ns/1ps

module isp_interval_serial_port
    import isp_pkg::*;
#(
    parameter int ICOUNT_W = ISP_IVL_COUNT_W
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic doze_mode,
    input wire logic serial_clk_in,
    output logic serial_clk_out,
    output logic serial_clk_oe_n,
    input wire logic enable_pin_in,
    output logic enable_pin_out,
    output logic enable_pin_oe_n,
    input wire logic data_in,
    output logic data_out,
    output logic data_out_oe_n,
    output logic general_purpose_pin,
    output logic irq
);

    // ****************************************************************
    // Registers and state
    // ****************************************************************
    typedef enum logic {ISP_ST_IDLE, ISP_ST_XFER} isp_state_e;

    isp_state_e state_reg;
    logic [15:0] ctrl_reg;
    logic [15:0] ivl_reg;
    logic [15:0] tx_reg;
    logic [15:0] rx_reg;
    logic [15:0] tx_sh_reg;
    logic [15:0] rx_sh_reg;
    logic [5:0] edge_cnt_reg;
    logic [ISP_DIV_W-1:0] div_cnt_reg;
    logic bit_phase_reg;
    logic clk_lvl_reg;
    logic [ICOUNT_W-1:0] timer_reg;
    logic overrun_reg;
    logic irq_pend_reg;
    logic unread_reg;
    logic sclk_s1_reg;
    logic sclk_s2_reg;
    logic sclk_s3_reg;
    logic en_s1_reg;
    logic en_s2_reg;
    logic din_s1_reg;
    logic din_s2_reg;

    // ****************************************************************
    // Decoded control fields
    // ****************************************************************
    logic [3:0] len_code;
    logic [4:0] nbits;
    logic [15:0] len_mask;
    logic [2:0] rate;
    logic master;
    logic interval;
    logic manual;
    logic halted;
    logic port_on;
    logic en_bit;
    logic clock_phase;
    logic clock_polarity;
    logic loopback;
    logic slave_en_act;

    assign len_code = ctrl_reg[ISP_CTL_COUNT_LSB +: ISP_CTL_COUNT_W];
    assign nbits = {1'b0, len_code} + 5'h01;
    assign rate = ctrl_reg[ISP_CTL_RATE_LSB +: ISP_CTL_RATE_W];
    assign master = ctrl_reg[ISP_CTL_MASTER_SELECT];
    assign interval = master & ivl_reg[ISP_IVL_INTERVAL_ENABLE];
    assign manual = master & ~ivl_reg[ISP_IVL_INTERVAL_ENABLE];
    assign halted = ctrl_reg[ISP_CTL_DOZE_DISABLE] & doze_mode;
    assign port_on = (len_code != 4'h0) & ~halted;
    assign en_bit = ctrl_reg[ISP_CTL_ENABLE];
    assign clock_phase = ctrl_reg[ISP_CTL_CLOCK_PHASE];
    assign clock_polarity = ctrl_reg[ISP_CTL_CLOCK_POLARITY];
    assign loopback = ivl_reg[ISP_IVL_LOOPBACK_ENABLE];
    assign slave_en_act = ~en_s2_reg;

    always_comb
    begin
        for (int i = 0; i < 16; i++)
        begin
            len_mask[i] = (5'(i) < nbits);
        end
    end

    // ****************************************************************
    // APB decode
    // ****************************************************************
    logic acc;
    logic hit_data;
    logic hit_ctrl;
    logic hit_ivl;
    logic hit_sts;
    logic data_wr;
    logic data_rd;
    logic [15:0] status_word;

    assign hit_data = (paddr == ISP_SERIAL_DATA_ADDR);
    assign hit_ctrl = (paddr == ISP_SERIAL_CONTROL_ADDR);
    assign hit_ivl = (paddr == ISP_INTERVAL_CONTROL_ADDR);
    assign hit_sts = (paddr == ISP_SERIAL_STATUS_ADDR);
    assign acc = psel & penable;
    assign data_wr = acc & pwrite & hit_data;
    assign data_rd = acc & ~pwrite & hit_data;
    assign pready = 1'b1;
    assign pslverr = acc & ~(hit_data | hit_ctrl | hit_ivl | hit_sts);

    always_comb
    begin
        status_word = 16'h0000;
        status_word[ISP_STS_OVERRUN_FLAG] = overrun_reg;
        status_word[ISP_STS_IRQ_PENDING] = irq_pend_reg;
        status_word[ISP_STS_EXCHANGE_IN_PROGRESS] = (state_reg == ISP_ST_XFER);
    end

    // Read data is captured in the setup cycle so it stands through the access cycle.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= 32'h00000000;
        end
        else if (psel && !penable && !pwrite)
        begin
            if (hit_data)
            begin
                prdata <= {16'h0000, rx_reg & len_mask};
            end
            else if (hit_ctrl)
            begin
                prdata <= {16'h0000, ctrl_reg};
            end
            else if (hit_ivl)
            begin
                prdata <= {16'h0000, ivl_reg};
            end
            else if (hit_sts)
            begin
                prdata <= {16'h0000, status_word};
            end
            else
            begin
                prdata <= 32'h00000000;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_reg <= ISP_SERIAL_CONTROL_RST;
            ivl_reg <= ISP_INTERVAL_CONTROL_RST;
            tx_reg <= ISP_SERIAL_DATA_RST;
        end
        else if (acc && pwrite)
        begin
            if (hit_ctrl)
            begin
                ctrl_reg <= pwdata[15:0];
            end
            if (hit_ivl)
            begin
                ivl_reg <= pwdata[15:0];
            end
            if (hit_data)
            begin
                tx_reg <= pwdata[15:0];
            end
        end
    end

    // ****************************************************************
    // Input synchronisers
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sclk_s1_reg <= 1'b0;
            sclk_s2_reg <= 1'b0;
            sclk_s3_reg <= 1'b0;
            en_s1_reg <= 1'b1;
            en_s2_reg <= 1'b1;
            din_s1_reg <= 1'b0;
            din_s2_reg <= 1'b0;
        end
        else
        begin
            sclk_s1_reg <= serial_clk_in;
            sclk_s2_reg <= sclk_s1_reg;
            sclk_s3_reg <= sclk_s2_reg;
            en_s1_reg <= enable_pin_in;
            en_s2_reg <= en_s1_reg;
            din_s1_reg <= data_in;
            din_s2_reg <= din_s1_reg;
        end
    end

    // ****************************************************************
    // Bit clock divider: one pulse per half bit period
    // ****************************************************************
    logic [ISP_DIV_W-1:0] half_lim;
    logic half_tick;
    logic bit_tick;
    logic start;

    assign half_lim = ISP_DIV_W'((ISP_HALF_DIV_BASE << rate) - 11'h001);
    assign half_tick = master & port_on & (div_cnt_reg == half_lim);
    assign bit_tick = half_tick & bit_phase_reg;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            div_cnt_reg <= '0;
            bit_phase_reg <= 1'b0;
        end
        else if (start || !master || !port_on)
        begin
            div_cnt_reg <= '0;
            bit_phase_reg <= 1'b0;
        end
        else if (half_tick)
        begin
            div_cnt_reg <= '0;
            bit_phase_reg <= ~bit_phase_reg;
        end
        else
        begin
            div_cnt_reg <= div_cnt_reg + 1'b1;
        end
    end

    // ****************************************************************
    // Shift engine
    // ****************************************************************
    logic xfer;
    logic lead_ev;
    logic trail_ev;
    logic sample_ev;
    logic shift_ev;
    logic done;
    logic abort;
    logic out_bit;
    logic din;
    logic [15:0] rx_final;
    logic [5:0] last_edge;
    logic start_manual;
    logic start_ivl;
    logic start_slave;

    assign xfer = (state_reg == ISP_ST_XFER);
    assign last_edge = {nbits, 1'b0} - 6'h01;
    assign out_bit = tx_sh_reg[len_code];
    assign din = loopback ? out_bit : din_s2_reg;

    always_comb
    begin
        if (master)
        begin
            lead_ev = xfer & half_tick & ~edge_cnt_reg[0];
            trail_ev = xfer & half_tick & edge_cnt_reg[0];
        end
        else
        begin
            lead_ev = xfer & ~halted & ((sclk_s2_reg ^ clock_polarity) & ~(sclk_s3_reg ^ clock_polarity));
            trail_ev = xfer & ~halted & (~(sclk_s2_reg ^ clock_polarity) & (sclk_s3_reg ^ clock_polarity));
        end
    end

    assign sample_ev = clock_phase ? trail_ev : lead_ev;
    assign shift_ev = clock_phase ? (lead_ev & (edge_cnt_reg != 6'h00)) : trail_ev;
    assign done = (lead_ev | trail_ev) & (edge_cnt_reg == last_edge);
    assign rx_final = sample_ev ? {rx_sh_reg[14:0], din} : rx_sh_reg;
    assign abort = xfer & ~master & ~slave_en_act & ~halted;

    assign start_manual = manual & port_on & en_bit & data_wr & ~xfer;
    assign start_ivl = interval & port_on & en_bit & ~xfer
        & (timer_reg == '0);
    assign start_slave = ~master & port_on & slave_en_act & ~xfer;
    assign start = start_manual | start_ivl | start_slave;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_reg <= ISP_ST_IDLE;
            tx_sh_reg <= 16'h0000;
            rx_sh_reg <= 16'h0000;
            edge_cnt_reg <= 6'h00;
            clk_lvl_reg <= 1'b0;
        end
        else if (start)
        begin
            state_reg <= ISP_ST_XFER;
            tx_sh_reg <= start_manual ? pwdata[15:0] : tx_reg;
            rx_sh_reg <= 16'h0000;
            edge_cnt_reg <= 6'h00;
            clk_lvl_reg <= 1'b0;
        end
        else if (done || abort)
        begin
            state_reg <= ISP_ST_IDLE;
            clk_lvl_reg <= 1'b0;
            edge_cnt_reg <= 6'h00;
        end
        else
        begin
            if (lead_ev || trail_ev)
            begin
                edge_cnt_reg <= edge_cnt_reg + 6'h01;
                clk_lvl_reg <= ~clk_lvl_reg;
            end
            if (sample_ev)
            begin
                rx_sh_reg <= {rx_sh_reg[14:0], din};
            end
            if (shift_ev)
            begin
                tx_sh_reg <= {tx_sh_reg[14:0], 1'b0};
            end
        end
    end

    // ****************************************************************
    // Interval timer
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            timer_reg <= '0;
        end
        else if (!interval)
        begin
            timer_reg <= '0;
        end
        else if (done)
        begin
            timer_reg <= ivl_reg[ISP_IVL_COUNT_LSB +: ICOUNT_W];
        end
        else if (bit_tick && !xfer && timer_reg != '0)
        begin
            timer_reg <= timer_reg - 1'b1;
        end
    end

    // ****************************************************************
    // Receive data, overrun and interrupt flags
    // ****************************************************************
    logic ovr_clr;

    assign ovr_clr = acc & pwrite & hit_sts & pwdata[ISP_STS_OVERRUN_FLAG];

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rx_reg <= ISP_SERIAL_DATA_RST;
        end
        else if (done)
        begin
            rx_reg <= rx_final & len_mask;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            unread_reg <= 1'b0;
        end
        else if (done)
        begin
            unread_reg <= 1'b1;
        end
        else if (data_rd)
        begin
            unread_reg <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            overrun_reg <= 1'b0;
        end
        else if (done && unread_reg && !data_rd)
        begin
            overrun_reg <= 1'b1;
        end
        else if (ovr_clr)
        begin
            overrun_reg <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq_pend_reg <= 1'b0;
        end
        else if (done)
        begin
            irq_pend_reg <= 1'b1;
        end
        else if (data_wr || data_rd)
        begin
            irq_pend_reg <= 1'b0;
        end
    end

    // ****************************************************************
    // Pin drivers
    // ****************************************************************
    logic en_act;
    logic en_lvl;
    logic clk_lvl;

    always_comb
    begin
        if (interval)
        begin
            en_act = en_bit & xfer;
        end
        else
        begin
            en_act = en_bit;
        end
    end

    assign en_lvl = ctrl_reg[ISP_CTL_SELECT_SENSE] ? en_act : ~en_act;
    assign clk_lvl = (clk_lvl_reg & xfer) ^ clock_polarity;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            serial_clk_out <= 1'b0;
            serial_clk_oe_n <= 1'b1;
            enable_pin_out <= 1'b0;
            enable_pin_oe_n <= 1'b1;
            data_out <= 1'b0;
            data_out_oe_n <= 1'b1;
            general_purpose_pin <= 1'b0;
            irq <= 1'b0;
        end
        else
        begin
            general_purpose_pin <= ctrl_reg[ISP_CTL_GP_PIN_LEVEL];
            irq <= irq_pend_reg & ctrl_reg[ISP_CTL_IRQ_ENABLE];
            serial_clk_out <= clk_lvl;
            enable_pin_out <= en_lvl;
            data_out <= out_bit;
            if (master)
            begin
                // Open-drain releases the pin for a high level instead of driving it.
                if (ctrl_reg[ISP_CTL_DRIVE_TYPE])
                begin
                    serial_clk_oe_n <= clk_lvl;
                    enable_pin_oe_n <= en_lvl;
                    data_out_oe_n <= out_bit;
                end
                else
                begin
                    serial_clk_oe_n <= 1'b0;
                    enable_pin_oe_n <= 1'b0;
                    data_out_oe_n <= 1'b0;
                end
            end
            else
            begin
                serial_clk_oe_n <= 1'b1;
                enable_pin_oe_n <= 1'b1;
                data_out_oe_n <= ~(slave_en_act & port_on);
            end
        end
    end

endmodule // isp_interval_serial_port

/* tb/isp_chk.sv */
// Checker for the interval serial port, watching only its top ports.
// Assumes settings are changed only while no exchange runs.
`timescale 1ns/1ps
module isp_chk
    import isp_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic serial_clk_out,
    input wire logic serial_clk_oe_n,
    input wire logic enable_pin_out,
    input wire logic enable_pin_oe_n,
    input wire logic general_purpose_pin,
    input wire logic irq
);
logic [15:0] ctl_q;
logic [15:0] ivl_q;
logic [3:0] age;
logic [10:0] hi_n;
logic wr;
logic st;
assign wr = psel && penable && pwrite;
assign st = age > 4'h2;
// ****************************************************************
// Shadow of the written settings and clock high time
// ****************************************************************
always_ff @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        ctl_q <= 16'h0000;
        ivl_q <= 16'h0000;
    end
    else if (wr && paddr == ISP_SERIAL_CONTROL_ADDR)
        ctl_q <= pwdata[15:0];
    else if (wr && paddr == ISP_INTERVAL_CONTROL_ADDR)
        ivl_q <= pwdata[15:0];
end
always_ff @(posedge pclk or negedge presetn)
begin
    if (!presetn)
        age <= 4'h0;
    else if (wr && (paddr == ISP_SERIAL_CONTROL_ADDR || paddr == ISP_INTERVAL_CONTROL_ADDR))
        age <= 4'h0;
    else if (age != 4'hf)
        age <= age + 4'h1;
end
always_ff @(posedge pclk or negedge presetn)
begin
    if (!presetn)
        hi_n <= 11'h000;
    else
        hi_n <= serial_clk_out ? hi_n + 11'h001 : 11'h000;
end
// ****************************************************************
// Properties
// ****************************************************************
default clocking cb @(posedge pclk);
endclocking
default disable iff (!presetn);
chk_gp_level: assert property (st |-> general_purpose_pin == ctl_q[7])
    else $error("gp pin differs from control bit");
chk_irq_gate: assert property (st && !ctl_q[10] |-> !irq)
    else $error("irq raised while disabled");
chk_slave_pins: assert property (st && !ctl_q[11] |-> serial_clk_oe_n && enable_pin_oe_n)
    else $error("slave mode drives clock or enable");
chk_enable_level: assert property (st && ctl_q[11] && !ivl_q[14]
    |-> enable_pin_out == (ctl_q[14] ~^ ctl_q[13]))
    else $error("enable pin level wrong");
chk_open_drain: assert property (st && ctl_q[11] && ctl_q[12]
    |-> serial_clk_oe_n == serial_clk_out && enable_pin_oe_n == enable_pin_out)
    else $error("open drain output drives high");
chk_totem_drive: assert property (st && ctl_q[11] && !ctl_q[12]
    |-> !serial_clk_oe_n && !enable_pin_oe_n)
    else $error("master pins not driven");
chk_half_bit: assert property ($fell(serial_clk_out) && st && ctl_q[11] && !ctl_q[8]
    && ctl_q[3:0] != 4'h0 |-> hi_n == (11'h004 << ctl_q[6:4]))
    else $error("serial clock half period wrong");
chk_irq_clear: assert property (psel && penable && paddr == ISP_SERIAL_DATA_ADDR
    |-> ##2 !irq)
    else $error("irq survives data access");
cover property (irq);
cover property ($fell(serial_clk_out) && ctl_q[12]);
cover property (!enable_pin_out && ivl_q[14]);
endmodule // isp_chk

bind isp_interval_serial_port isp_chk chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .serial_clk_out(serial_clk_out), .serial_clk_oe_n(serial_clk_oe_n),
    .enable_pin_out(enable_pin_out), .enable_pin_oe_n(enable_pin_oe_n),
    .general_purpose_pin(general_purpose_pin), .irq(irq));

/* tb/isp_slave_model.sv */
// Serial slave device: captures on the rising clock edge, shifts on the falling one.
// Assumes an active-low select; the clock may idle at either level.
`timescale 1ns/1ps
module isp_slave_model (
    input wire logic sck,
    input wire logic sel_n,
    input wire logic mosi,
    input wire logic [15:0] reply,
    output logic miso,
    output logic [15:0] got
);
logic [15:0] sh = 16'h0000;
logic armed = 1'b0;
initial got = 16'h0000;
always @(negedge sel_n)
begin
    sh = reply;
    got = 16'h0000;
    armed = 1'b0;
end
always @(posedge sel_n)
    armed = 1'b0;
always @(posedge sck)
    if (!sel_n)
    begin
        got = {got[14:0], mosi};
        armed = 1'b1;
    end
// Shifting waits for the first capture, so a clock that falls with the select or a
// leading falling edge never loses the first bit.
always @(negedge sck)
    if (!sel_n && armed)
        sh = {sh[14:0], 1'b0};
// A released line shows the inverse of the top shift register bit.
assign miso = sh[15] ^ sel_n;
endmodule // isp_slave_model

/* tb/isp_interval_serial_port_bench.sv */
// Self-checking bench for the interval serial port.
// Assumes pull-ups on clock, enable and data out wires.
`timescale 1ns/1ps
module isp_interval_serial_port_bench
    import isp_pkg::*;
;
localparam logic [31:0] A_DT = ISP_SERIAL_DATA_ADDR;
localparam logic [31:0] A_CT = ISP_SERIAL_CONTROL_ADDR;
localparam logic [31:0] A_IV = ISP_INTERVAL_CONTROL_ADDR;
localparam logic [31:0] A_ST = ISP_SERIAL_STATUS_ADDR;
logic pclk, presetn, psel, penable, pwrite, doze_mode;
logic [31:0] paddr, pwdata, prdata;
logic pready, pslverr, sck_o, sck_oe_n, en_o, en_oe_n, dout, dout_oe_n, gp, irq, miso, err;
logic [15:0] reply, got, rx;
wire sck_w = sck_oe_n ? 1'b1 : sck_o;
wire en_w = en_oe_n ? 1'b1 : en_o;
wire mosi_w = dout_oe_n ? 1'b1 : dout;
int bad_count, tests_run;
isp_interval_serial_port dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .doze_mode(doze_mode), .serial_clk_in(sck_w),
    .serial_clk_out(sck_o), .serial_clk_oe_n(sck_oe_n), .enable_pin_in(en_w),
    .enable_pin_out(en_o), .enable_pin_oe_n(en_oe_n), .data_in(miso), .data_out(dout),
    .data_out_oe_n(dout_oe_n), .general_purpose_pin(gp), .irq(irq));
isp_slave_model part_u (.sck(sck_w), .sel_n(en_w), .mosi(mosi_w), .reply(reply),
    .miso(miso), .got(got));
// ****************************************************************
// Bus cycles and comparison
// ****************************************************************
task bus(input logic w, input logic [31:0] a, input logic [15:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {16'h0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rx = prdata[15:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
endtask
task chk(input string n, input logic [15:0] s, input logic [15:0] e);
    tests_run++;
    if (s !== e)
    begin
        bad_count++;
        $display("unexpected %s expected %h seen %h", n, e, s);
    end
endtask
task wx(input logic v);
    int i;
    i = 0;
    do
    begin
        bus(1'b0, A_ST, 16'h0000);
        i++;
    end
    while (rx[13] !== v && i < 400);
    chk("exchange", {15'h0000, rx[13]}, {15'h0000, v});
endtask
// ****************************************************************
// Scenarios
// ****************************************************************
task t_reset;
    logic [31:0] a[4];
    a = '{A_DT, A_CT, A_IV, A_ST};
    foreach (a[i])
    begin
        bus(1'b0, a[i], 16'h0000);
        chk("reset value", rx, 16'h0000);
        chk("mapped error", {15'h0000, err}, 16'h0000);
    end
    bus(1'b0, A_ST + 32'h00000004, 16'h0000);
    chk("unmapped error", {15'h0000, err}, 16'h0001);
    chk("unmapped data", rx, 16'h0000);
    $display("test reset done");
endtask
task t_manual;
    reply = 16'hc3a5;
    bus(1'b1, A_CT, 16'h4c99);
    bus(1'b1, A_DT, 16'hfea5);
    wx(1'b1);
    wx(1'b0);
    chk("sent word", got, 16'h02a5);
    chk("irq", {15'h0000, irq}, 16'h0001);
    bus(1'b0, A_ST, 16'h0000);
    chk("pending", rx & 16'h4000, 16'h4000);
    bus(1'b0, A_DT, 16'h0000);
    chk("rx word", rx, 16'h030e);
    bus(1'b0, A_ST, 16'h0000);
    chk("pending cleared", rx & 16'h4000, 16'h0000);
    $display("test manual done");
endtask
task t_loop;
    bus(1'b1, A_IV, 16'h8000);
    bus(1'b1, A_DT, 16'h1234);
    wx(1'b0);
    bus(1'b1, A_DT, 16'hfd57);
    wx(1'b0);
    bus(1'b0, A_ST, 16'h0000);
    chk("overrun", rx & 16'h8000, 16'h8000);
    bus(1'b1, A_ST, 16'h0000);
    bus(1'b0, A_ST, 16'h0000);
    chk("overrun kept", rx & 16'h8000, 16'h8000);
    bus(1'b1, A_ST, 16'h8000);
    bus(1'b0, A_ST, 16'h0000);
    chk("overrun cleared", rx & 16'h8000, 16'h0000);
    bus(1'b0, A_DT, 16'h0000);
    chk("loop word", rx, 16'h0157);
    bus(1'b1, A_IV, 16'h0000);
    $display("test loopback done");
endtask
task t_interval;
    bus(1'b1, A_CT, 16'h4c90);
    wx(1'b0);
    bus(1'b1, A_IV, 16'h4005);
    bus(1'b1, A_CT, 16'h5807);
    repeat (2)
    begin
        wx(1'b1);
        chk("select on", {15'h0000, en_w}, 16'h0000);
        wx(1'b0);
        chk("select off", {15'h0000, en_w}, 16'h0001);
        chk("ivl word", got, 16'h0057);
    end
    bus(1'b1, A_CT, 16'h5800);
    wx(1'b0);
    bus(1'b1, A_IV, 16'h0000);
    $display("test interval done");
endtask
task t_doze;
    bus(1'b1, A_CT, 16'hc827);
    doze_mode <= 1'b1;
    bus(1'b1, A_DT, 16'h00a5);
    repeat (40) @(posedge pclk);
    bus(1'b0, A_ST, 16'h0000);
    chk("doze stop", rx & 16'h2000, 16'h0000);
    bus(1'b1, A_CT, 16'h4827);
    bus(1'b1, A_DT, 16'h00a5);
    wx(1'b1);
    wx(1'b0);
    chk("doze word", got, 16'h00a5);
    doze_mode <= 1'b0;
    $display("test doze done");
endtask
task t_mode3;
    reply = 16'h6c00;
    bus(1'b1, A_CT, 16'h4820);
    wx(1'b0);
    bus(1'b1, A_CT, 16'h0b10);
    bus(1'b1, A_CT, 16'h4b17);
    bus(1'b1, A_DT, 16'h00c3);
    wx(1'b1);
    wx(1'b0);
    chk("mode 3 sent", got, 16'h00c3);
    bus(1'b0, A_DT, 16'h0000);
    chk("mode 3 rx", rx, 16'h006c);
    $display("test phase polarity done");
endtask
task close_out;
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
        $display("Run complete: PASS");
    else
        $display("Run complete: FAIL");
    $finish;
endtask
initial
begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
end
initial
begin
    #1000000;
    bad_count++;
    close_out;
end
initial
begin
    {presetn, psel, penable, pwrite, doze_mode} = 5'h00;
    paddr = 32'h00000000;
    pwdata = 32'h00000000;
    reply = 16'h0000;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_manual;
    t_loop;
    t_interval;
    t_doze;
    t_mode3;
    close_out;
end
endmodule // isp_interval_serial_port_bench
